/* inc/asr_pkg.sv */
// package for the serial converter readout host
// assumes a 25 MHz system clock and a converter on a three-wire serial link
package asr_pkg;

  // ------------------------------------------------------------------
  // register map of the host's own command port
  // ------------------------------------------------------------------
  localparam logic [3:0] ASR_REG_CTRL    = 4'h0; // enable, variant, length
  localparam logic [3:0] ASR_REG_DIV     = 4'h1; // serial clock divider
  localparam logic [3:0] ASR_REG_PERIOD  = 4'h2; // sample period in serial clocks
  localparam logic [3:0] ASR_REG_STATUS  = 4'h3; // busy, valid, overrun
  localparam logic [3:0] ASR_REG_DATA    = 4'h4; // oldest result, pops fifo

  // ------------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------------
  localparam int ASR_CTRL_EN_BIT       = 0;  // run periodic sampling
  localparam int ASR_CTRL_VAR_LSB      = 1;  // converter variant, 2 bits
  localparam int ASR_CTRL_FORCE16_BIT  = 3;  // frame 16 bits for any variant
  localparam logic [31:0] ASR_CTRL_RESET   = 32'h0000_0000;
  localparam logic [7:0]  ASR_DIV_RESET    = 8'h03;  // serial clock divider
  localparam logic [15:0] ASR_PERIOD_RESET = 16'h0020; // serial clocks per sample

  // ------------------------------------------------------------------
  // converter variants and word lengths
  // ------------------------------------------------------------------
  localparam logic [1:0] ASR_VAR_12 = 2'h0; // 12-bit result, 16-bit word
  localparam logic [1:0] ASR_VAR_10 = 2'h1; // 10-bit result, 14-bit word
  localparam logic [1:0] ASR_VAR_8  = 2'h2; // 8-bit result, 12-bit word
  localparam logic [4:0] ASR_LEN_16 = 5'h10;
  localparam logic [4:0] ASR_LEN_14 = 5'h0E;
  localparam logic [4:0] ASR_LEN_12 = 5'h0C;
  localparam int ASR_WORD_W  = 16; // widest word
  localparam int ASR_FIFO_D  = 4;  // result fifo depth

  // host sequencer states
  typedef enum logic [3:0] {
    ASR_IDLE  = 4'b0001, // waiting for the sample timer
    ASR_SYNC  = 4'b0010, // watching serial clock high, low, high
    ASR_SHIFT = 4'b0100, // frame low, bits being taken
    ASR_DONE  = 4'b1000  // frame released, word pushed
  } asr_state_e;

endpackage

/* hw/asr_fifo.sv */
// small first-in first-out buffer for received results
// assumes one clock and an active low asynchronous reset
`timescale 1ns/1ps
module asr_fifo
  import asr_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
)(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage words
    logic [AW-1:0]               wr;    // write pointer
    logic [AW-1:0]               rd;    // read pointer
    logic [AW:0]                 count; // words held
  } asr_fifo_s;

  asr_fifo_s st;
  asr_fifo_s next_st;
  logic      push;
  logic      pop;

  // honest flags from the word count
  assign in_ready  = (st.count != (AW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // next state of pointers and storage
  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wr] = in_data;
      next_st.wr         = st.wr + AW'(1);
    end
    if (pop)
    begin
      next_st.rd = st.rd + AW'(1);
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // register the state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

endmodule

/* hw/asr_host.sv */
// readout host for a clock-driven successive approximation converter
// assumes the converter's chip select, serial clock and data on plain pins;
// software drives a simple strobe port, results wait in a small fifo
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
module asr_host
  import asr_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             SERIAL_CLOCK,
  output logic             TX_FRAME_SYNC_N,
  input  wire logic        SERIAL_RESULT_LINE
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    asr_state_e  state;       // sequencer state
    logic        enable;      // periodic sampling on
    logic [1:0]  variant;     // converter resolution
    logic        force16;     // frame 16 bits regardless
    logic [7:0]  divider;     // serial_clock_divider
    logic [15:0] period;      // serial clocks per sample
    logic [7:0]  div_cnt;     // master clocks toward half period
    logic        sclk;        // serial clock level
    logic [15:0] tmr;         // sample timer in serial clocks
    logic        pending;     // timer fired, frame not yet started
    logic [1:0]  sync_step;   // clock phases seen since request
    logic [4:0]  bits;        // bits taken in this frame
    logic [15:0] shreg;       // incoming word
    logic [31:0] rdata;       // read data register
    logic        overrun;     // result lost to a full fifo
    logic        d1;          // data synchroniser first stage
    logic        d2;          // data synchroniser second stage
  } asr_host_s;

  asr_host_s st;
  asr_host_s next_st;
  logic      rise;            // serial clock about to rise
  logic      fall;            // serial clock about to fall
  logic      push;            // word into fifo
  logic      f_ready;         // fifo has room
  logic [15:0] push_data;     // right-justified result
  logic      f_valid;         // fifo holds a word
  logic [15:0] f_data;        // oldest result
  logic      pop;             // software reads data

  // word length per variant and framing choice
  function automatic logic [4:0] word_len(input logic [1:0] v, input logic f16);
    logic [4:0] l;
    l = ASR_LEN_16;
    if (!f16)
    begin
      if (v == ASR_VAR_10)
        l = ASR_LEN_14;
      else if (v == ASR_VAR_8)
        l = ASR_LEN_12;
    end
    return l;
  endfunction

  // result right-justified, extra tail bits dropped
  function automatic logic [15:0] justify(input logic [15:0] w, input logic [4:0] n,
                                          input logic [4:0] len);
    logic [15:0] r;
    r = w >> (len - n);
    return r;
  endfunction

  // ------------------------------------------------------------------
  // result buffer
  // ------------------------------------------------------------------
  asr_fifo #(
    .WIDTH (ASR_WORD_W),
    .DEPTH (ASR_FIFO_D)
  ) u_fifo (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   (push_data),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_data)
  );

  // serial clock from divider of the master clock
  assign rise = (st.div_cnt == st.divider) && !st.sclk;
  assign fall = (st.div_cnt == st.divider) && st.sclk;
  assign pop  = RD && (ADDR == ASR_REG_DATA) && f_valid;
  assign push = (st.state == ASR_DONE);
  assign push_data = justify(st.shreg, word_len(st.variant, 1'b0),
                             word_len(st.variant, st.force16));

  assign SERIAL_CLOCK    = st.sclk;
  assign TX_FRAME_SYNC_N = (st.state != ASR_SHIFT);
  assign RDATA           = st.rdata;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // data pin through two flops
    next_st.d1 = SERIAL_RESULT_LINE;
    next_st.d2 = st.d1;
    // clock divider
    if (st.div_cnt == st.divider)
    begin
      next_st.div_cnt = '0;
      next_st.sclk    = !st.sclk;
    end
    else
    begin
      next_st.div_cnt = st.div_cnt + 8'h01;
    end
    // sample timer counts whole serial clocks
    if (st.enable && rise)
    begin
      if (st.tmr >= st.period - 16'h0001)
      begin
        next_st.tmr     = '0;
        next_st.pending = 1'b1;
      end
      else
      begin
        next_st.tmr = st.tmr + 16'h0001;
      end
    end
    if (!st.enable)
      next_st.tmr = '0;
    // sequencer
    case (st.state)
      ASR_IDLE:
      begin
        if (st.pending)
        begin
          next_st.pending   = 1'b0;
          next_st.sync_step = '0;
          next_st.state     = ASR_SYNC;
        end
      end
      ASR_SYNC:
      begin
        // high, low, high again
        if (st.sync_step == 2'h0 && (rise || st.sclk))
          next_st.sync_step = 2'h1;
        else if (st.sync_step == 2'h1 && fall)
          next_st.sync_step = 2'h2;
        else if (st.sync_step == 2'h2 && rise)
        begin
          next_st.bits  = '0;
          next_st.shreg = '0;
          next_st.state = ASR_SHIFT; // frame low starts conversion
        end
      end
      ASR_SHIFT:
      begin
        // take each bit just before the falling edge that replaces it
        // the first falling edge thus catches the zero shown at frame start;
        // dividers below 2 would outrun the data synchroniser
        if (fall)
        begin
          next_st.shreg = {st.shreg[14:0], st.d2};
          next_st.bits  = st.bits + 5'h01;
          // frame released on the last falling edge
          if (st.bits + 5'h01 == word_len(st.variant, st.force16))
            next_st.state = ASR_DONE;
        end
      end
      ASR_DONE:
      begin
        next_st.state = ASR_IDLE;
        if (!f_ready)
          next_st.overrun = 1'b1;
      end
      default:
      begin
        next_st.state = ASR_IDLE;
      end
    endcase
    // software writes
    if (WR)
    begin
      if (ADDR == ASR_REG_CTRL)
      begin
        next_st.enable  = WDATA[ASR_CTRL_EN_BIT];
        next_st.variant = WDATA[ASR_CTRL_VAR_LSB +: 2];
        next_st.force16 = WDATA[ASR_CTRL_FORCE16_BIT];
      end
      else if (ADDR == ASR_REG_DIV)
      begin
        next_st.divider = WDATA[7:0];
        next_st.div_cnt = '0;
      end
      else if (ADDR == ASR_REG_PERIOD)
      begin
        next_st.period = WDATA[15:0];
      end
      else if (ADDR == ASR_REG_STATUS)
      begin
        // write one clears overrun unless set again now
        if (WDATA[2] && !(push && !f_ready))
          next_st.overrun = 1'b0;
      end
    end
    // software reads, data valid next cycle only
    next_st.rdata = '0;
    if (RD)
    begin
      if (ADDR == ASR_REG_CTRL)
        next_st.rdata = {28'h0, st.force16, st.variant, st.enable};
      else if (ADDR == ASR_REG_DIV)
        next_st.rdata = {24'h0, st.divider};
      else if (ADDR == ASR_REG_PERIOD)
        next_st.rdata = {16'h0, st.period};
      else if (ADDR == ASR_REG_STATUS)
        next_st.rdata = {29'h0, st.overrun, f_valid, (st.state != ASR_IDLE)};
      else if (ADDR == ASR_REG_DATA && f_valid)
        next_st.rdata = {15'h0, 1'b1, f_data}; // empty fifo reads as zero
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st         <= '0;
      st.state   <= ASR_IDLE;
      st.divider <= ASR_DIV_RESET;
      st.period  <= ASR_PERIOD_RESET;
      st.d1      <= 1'b1;
      st.d2      <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

/* verif/asr_host_properties.sv */
// checker for the readout host, sees only the top ports
// assumes one clock domain; bound from the bench top
`timescale 1ns/1ps
module asr_host_properties
  import asr_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic [3:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        SERIAL_CLOCK,
  input wire logic        TX_FRAME_SYNC_N,
  input wire logic        SERIAL_RESULT_LINE
);
  // ------------------------------------------------------------
  // shadow config and frame counters
  // ------------------------------------------------------------
  logic [3:0]  ctl;   // shadow control
  logic [7:0]  dv;    // shadow divider
  logic [15:0] per;   // shadow period
  logic        sc_q;  // last serial clock
  logic [4:0]  rises; // clock rises in frame
  logic [31:0] gap;   // cycles since frame start
  logic        seen;  // a start seen, config untouched
  logic [4:0]  len;   // expected word length
  assign len = ctl[3] ? ASR_LEN_16 : ctl[2:1] == ASR_VAR_10 ? ASR_LEN_14
             : ctl[2:1] == ASR_VAR_8 ? ASR_LEN_12 : ASR_LEN_16;
  // track writes, count rises, time starts
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      ctl <= ASR_CTRL_RESET[3:0];
      dv <= ASR_DIV_RESET;
      per <= ASR_PERIOD_RESET;
      sc_q <= 1'b0;
      rises <= 5'h00;
      gap <= 32'h0;
      seen <= 1'b0;
    end
    else
    begin
      sc_q <= SERIAL_CLOCK;
      rises <= TX_FRAME_SYNC_N ? 5'h00 : rises + 5'(SERIAL_CLOCK && !sc_q);
      gap <= $fell(TX_FRAME_SYNC_N) ? 32'h1 : gap + 32'h1;
      if (WR)
        seen <= 1'b0; // any write restarts timing
      else if ($fell(TX_FRAME_SYNC_N))
        seen <= 1'b1;
      if (WR && ADDR == ASR_REG_CTRL)
        ctl <= WDATA[3:0];
      if (WR && ADDR == ASR_REG_DIV)
        dv <= WDATA[7:0];
      if (WR && ADDR == ASR_REG_PERIOD)
        per <= WDATA[15:0];
    end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_start; $fell(TX_FRAME_SYNC_N); endsequence
  sequence s_end; $rose(TX_FRAME_SYNC_N); endsequence
  sequence s_low8; !TX_FRAME_SYNC_N [*8]; endsequence
  property p_len; s_end |-> rises == len; endproperty
  property p_hold; s_start |-> s_low8; endproperty
  property p_sync; s_start |-> SERIAL_CLOCK; endproperty
  property p_end; s_end |-> !SERIAL_CLOCK; endproperty
  property p_gap; s_start ##0 seen |-> gap == (32'(dv) + 32'h1) * 32'(per) * 32'h2;
  endproperty
  property p_idle; !RD |=> RDATA == 32'h0; endproperty
  property p_unmap; RD && ADDR > ASR_REG_DATA |=> RDATA == 32'h0; endproperty
  property p_just; RD && ADDR == ASR_REG_DATA |=> RDATA[31:17] == 15'h0; endproperty
  property p_empty;
    RD && ADDR == ASR_REG_DATA |=> RDATA[16] || RDATA == 32'h0;
  endproperty
  property p_busy;
    RD && ADDR == ASR_REG_STATUS && !TX_FRAME_SYNC_N |=> RDATA[0];
  endproperty
  a_len: assert property (p_len) else $error("frame clock count wrong");
  a_hold: assert property (p_hold) else $error("frame cut short");
  a_sync: assert property (p_sync) else $error("frame start off clock high");
  a_end: assert property (p_end) else $error("frame end off clock low");
  a_gap: assert property (p_gap) else $error("sample spacing wrong");
  a_idle: assert property (p_idle) else $error("read data without read");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_just: assert property (p_just) else $error("result not right aligned");
  a_empty: assert property (p_empty) else $error("empty data read not zero");
  a_busy: assert property (p_busy) else $error("busy low in frame");
endmodule

/* verif/asr_conv_model.sv */
// converter model at the far end of the serial link
// assumes clock and frame from the host, word given left aligned
`timescale 1ns/1ps
module asr_conv_model
(
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [4:0]  dev_len,
  input  wire logic [15:0] word,
  output logic             sdo
);
  int cnt; // falling edges in frame
  initial sdo = 1'b1;
  // frame fall: show first leading zero
  always @(negedge cs_n)
  begin
    cnt = 0;
    sdo = word[15];
  end
  // shift on falling clock, release line after last bit
  always @(negedge sclk)
    if (!cs_n)
    begin
      cnt = cnt + 1;
      sdo = (cnt < dev_len) ? word[15-cnt] : ~sdo;
    end
  // frame release, early or not: line undriven
  always @(posedge cs_n)
    sdo = ~sdo;
endmodule

/* verif/asr_host_tb_top.sv */
// bench for the readout host with a converter model
// assumes 25 MHz clock, strobe register port
`timescale 1ns/1ps
module asr_host_tb_top;
  logic CLK, RESET_N, WR, RD, SERIAL_CLOCK, TX_FRAME_SYNC_N, SERIAL_RESULT_LINE;
  logic [3:0]  ADDR;
  logic [31:0] WDATA, RDATA, v;
  logic [4:0]  dev_len;              // device word length
  logic [15:0] word;                 // device frame word
  int bad_count, checks_done, cyc, t_prev, t_last;
  logic fq = 1'b1;                   // frame at last low phase
  logic [3:0]  ctl_t [5] = '{4'h1, 4'h3, 4'h5, 4'hB, 4'hD};
  logic [4:0]  len_t [5] = '{5'h10, 5'h0E, 5'h0C, 5'h0E, 5'h0C};
  logic [15:0] wrd_t [5] = '{16'h0A5C, 16'h0B4C, 16'h0960, 16'h069C, 16'h03C0};
  logic [31:0] exp_t [5] = '{32'h10A5C, 32'h102D3, 32'h10096, 32'h101A7, 32'h1003C};
  asr_host DUT (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SERIAL_CLOCK(SERIAL_CLOCK),
    .TX_FRAME_SYNC_N(TX_FRAME_SYNC_N), .SERIAL_RESULT_LINE(SERIAL_RESULT_LINE));
  asr_conv_model conv (.sclk(SERIAL_CLOCK), .cs_n(TX_FRAME_SYNC_N),
    .dev_len(dev_len), .word(word), .sdo(SERIAL_RESULT_LINE));
  // ------------------------------------------------------------
  // clock and frame start stamps
  // ------------------------------------------------------------
  initial
  begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  always @(negedge CLK)
  begin
    cyc <= cyc + 1;
    fq <= TX_FRAME_SYNC_N;
    if (fq && !TX_FRAME_SYNC_N)
    begin
      t_prev <= t_last;
      t_last <= cyc;
    end
  end
  // ------------------------------------------------------------
  // port tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    d = RDATA;
    @(posedge CLK);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one whole frame, busy checked inside it
  task automatic frame();
    int n;
    n = 0;
    while (TX_FRAME_SYNC_N !== 1'b0 && n < 3000)
    begin
      @(posedge CLK);
      n++;
    end
    rd(4'h3, v);
    chk(v & 32'h1, 32'h1);
    while (TX_FRAME_SYNC_N !== 1'b1 && n < 3000)
    begin
      @(posedge CLK);
      n++;
    end
    chk(32'(n < 3000), 32'h1);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    RESET_N = 1'b0;
    {ADDR, WDATA, WR, RD, dev_len, word} = '0;
    repeat (10) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    rd(4'h0, v);
    chk(v, 32'h0);
    rd(4'h1, v);
    chk(v, 32'h3);
    rd(4'h2, v);
    chk(v, 32'h20);
    wr(4'h7, 32'hFFFF_FFFF);
    rd(4'h7, v);
    chk(v, 32'h0);
    rd(4'h3, v);
    chk(v, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      dev_len <= len_t[i];
      word <= wrd_t[i];
      wr(4'h0, {28'h0, ctl_t[i]});
      frame();
      wr(4'h0, 32'h0);
      rd(4'h4, v);
      chk(v, exp_t[i]);
      rd(4'h4, v);
      chk(v, 32'h0);
    end
    dev_len <= 5'h10;
    word <= 16'h0123;
    wr(4'h1, 32'h4);
    rd(4'h1, v);
    chk(v, 32'h4);
    wr(4'h2, 32'h18);
    wr(4'h0, 32'h1);
    repeat (5) frame();
    wr(4'h0, 32'h0);
    chk(32'(t_last - t_prev), 32'hF0);
    rd(4'h3, v);
    chk(v, 32'h6);
    repeat (4)
    begin
      rd(4'h4, v);
      chk(v, 32'h10123);
    end
    wr(4'h3, 32'h4);
    rd(4'h3, v);
    chk(v, 32'h0);
    give_verdict();
  end
  // watchdog against a hang
  initial
  begin
    #1000000;
    bad_count++;
    give_verdict();
  end
endmodule
bind asr_host asr_host_properties chk_i (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SERIAL_CLOCK(SERIAL_CLOCK),
  .TX_FRAME_SYNC_N(TX_FRAME_SYNC_N), .SERIAL_RESULT_LINE(SERIAL_RESULT_LINE));
